// ---- rtl/hemwm_pkg.sv ----
// Constants, encodings and carrier types for the host memory window and mailbox block
package hemwm_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int RAM_AW = 16;
  localparam int RAM_DW = 32;

  // ----------------------------------------------------------------
  // Host byte offsets (twelve bytes)
  // ----------------------------------------------------------------
  localparam logic [3:0] HOFF_H2E = 4'h0;
  localparam logic [3:0] HOFF_E2H = 4'h1;
  localparam logic [3:0] HOFF_ADDR0 = 4'h2;
  localparam logic [3:0] HOFF_ADDR1 = 4'h3;
  localparam logic [3:0] HOFF_SRC0 = 4'h8;
  localparam logic [3:0] HOFF_SRC1 = 4'h9;
  localparam logic [3:0] HOFF_MSK0 = 4'hA;
  localparam logic [3:0] HOFF_MSK1 = 4'hB;
  localparam logic [3:0] HOFF_LAST = 4'hB;

  // ----------------------------------------------------------------
  // Controller APB byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] EOFF_H2E = 8'h00;
  localparam logic [7:0] EOFF_E2H = 8'h04;
  localparam logic [7:0] EOFF_E2H_CLR = 8'h08;
  localparam logic [7:0] EOFF_SRC = 8'h0C;
  localparam logic [7:0] EOFF_MSK = 8'h10;
  localparam logic [7:0] EOFF_RGN = 8'h14;
  localparam logic [7:0] EOFF_RGN_STRIDE = 8'h08;
  localparam logic [7:0] EOFF_LAST = 8'h20;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int ADDR_REGION_BIT = 15;
  localparam int SRC_ECWR_BIT = 0;
  localparam logic [7:0] MBOX_RST = 8'h00;
  localparam logic [15:0] REG16_RST = 16'h0000;
  localparam logic [31:0] WORD_RST = 32'h00000000;

  // ----------------------------------------------------------------
  // Transfer modes held in address bits 1:0
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ACC_BYTE = 2'b00,
    ACC_HALF = 2'b01,
    ACC_WORD = 2'b10,
    ACC_WORD_INC = 2'b11
  } hemwm_acc_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RAM = 2'b01,
    ST_ACK = 2'b10
  } hemwm_state_t;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic wr;
    logic [3:0] addr;
    logic [7:0] wdata;
  } hemwm_host_req_t;

  typedef struct packed {
    logic we;
    logic [RAM_AW-1:0] addr;
    logic [3:0] be;
    logic [RAM_DW-1:0] wdata;
  } hemwm_ram_req_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } hemwm_apb_req_t;

endpackage

// ---- rtl/hemwm_top.sv ----
// Host memory window and mailbox block: host byte port, controller APB, RAM port, events
// Functional notes
// - Twelve host byte registers plus controller-only registers reached over APB.
// - Host reads inside the read window fetch RAM with no firmware help.
// - Host writes inside the write window reach RAM with no firmware help.
// - Active-low system reset returns all state to defaults.
// - Host write of host-to-controller mailbox raises controller interrupt bit.
// - Controller mailbox write drives active-high serial IRQ level, polarity zero.
// - Active-low soft event asserts when any enabled soft bit is set.
// - Soft event also asserts on mailbox written flag when its enable set.
// - Active-low soft event level matches the host SMI pin level.
// - Mailbox event line is active-high level of the mailbox written flag.
// - Soft event line is active high, inverse of the polarity-one signal.
// - Both event lines go out to the PME and SMI logic.
// - One 8-bit message per direction; writes raise receiver interrupts.
// - Host map: two mailbox bytes, two address bytes, four data bytes, two source and two enable bytes.
// - Host data byte read returns RAM at the address register location.
// - Host data byte write updates RAM through the direct RAM port.
// - RAM transfers are one byte, two-byte or four-byte blocks.
// - Auto-increment advances the RAM address on repeated data accesses.
// - Two regions, each base, read and write limit, controller-only.
// - Read and write limits independent; read limit zero makes write-only.
// - Writing one to a controller-to-host mailbox bit clears it, either side.
`timescale 1ns/1ps
`default_nettype none

module hemwm_top (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic host_req,
  input wire hemwm_pkg::hemwm_host_req_t host_cmd,
  output logic host_ack,
  output logic [7:0] host_rdata,
  input wire hemwm_pkg::hemwm_apb_req_t apb_req,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic ram_req,
  output hemwm_pkg::hemwm_ram_req_t ram_cmd,
  input wire logic ram_ack,
  input wire logic [31:0] ram_rdata,
  output logic window_ec_irq_bit,
  output logic mailbox_event_line,
  output logic soft_irq_event_line,
  output logic serirq_sel0_level,
  output logic serirq_sel1_n
);
  import hemwm_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0] h2e_q, h2e_d, e2h_q, e2h_d;
  logic h2e_irq_q, h2e_irq_d;
  logic [15:0] src_q, src_d, msk_q, msk_d, addr_q, addr_d, src_set;
  logic [31:0] buf_q, buf_d, prdata_q, prdata_d;
  logic [15:0] base_q [2];
  logic [15:0] base_d [2];
  logic [15:0] rlim_q [2];
  logic [15:0] rlim_d [2];
  logic [15:0] wlim_q [2];
  logic [15:0] wlim_d [2];
  hemwm_state_t st_q, st_d;
  logic [1:0] pidx_q, pidx_d;
  logic pwr_q, pwr_d, ack_q, ack_d, ramreq_q, ramreq_d;
  logic [7:0] hrd_q, hrd_d;
  hemwm_ram_req_t ram_q, ram_d;

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  logic accept, is_data, first, last, rsel, rd_ok, wr_ok, inc;
  logic apb_setup, apb_wr, apb_rd, apb_hit;
  logic [1:0] idx;
  logic [3:0] be;
  logic [14:0] blk_off;
  logic [31:0] wmerge;
  hemwm_acc_t acc;

  assign accept = host_req && !ack_q && (st_q == ST_IDLE) && (host_cmd.addr <= HOFF_LAST);
  assign is_data = host_cmd.addr[3:2] == 2'b01;
  assign idx = host_cmd.addr[1:0];
  assign acc = hemwm_acc_t'(addr_q[1:0]);
  assign rsel = addr_q[ADDR_REGION_BIT];
  assign inc = acc == ACC_WORD_INC;
  assign apb_setup = apb_req.psel && !apb_req.penable;
  assign apb_wr = apb_req.psel && apb_req.penable && apb_req.pwrite;
  assign apb_rd = apb_req.psel && apb_req.penable && !apb_req.pwrite;
  assign apb_hit = (apb_req.paddr <= EOFF_LAST) && (apb_req.paddr[1:0] == 2'b00);
  assign src_set = {apb_wr && apb_req.paddr == EOFF_SRC ? apb_req.pwdata[15:1] : 15'h0000,
    apb_wr && apb_req.paddr == EOFF_E2H};

  // Block boundaries per transfer mode
  always_comb begin
    unique case (acc)
      ACC_BYTE: begin
        first = 1'b1;
        last = 1'b1;
        be = 4'h1 << idx;
        blk_off = {addr_q[14:2], idx};
      end
      ACC_HALF: begin
        first = !idx[0];
        last = idx[0];
        be = idx[1] ? 4'hC : 4'h3;
        blk_off = {addr_q[14:2], idx[1], 1'b0};
      end
      ACC_WORD, ACC_WORD_INC: begin
        first = idx == 2'b00;
        last = idx == 2'b11;
        be = 4'hF;
        blk_off = {addr_q[14:2], 2'b00};
      end
    endcase
  end

  assign rd_ok = {1'b0, blk_off} < rlim_q[rsel];
  assign wr_ok = {1'b0, blk_off} < wlim_q[rsel];

  always_comb begin
    wmerge = buf_q;
    wmerge[8*idx +: 8] = host_cmd.wdata;
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    h2e_d = h2e_q;
    h2e_irq_d = h2e_irq_q;
    e2h_d = e2h_q;
    src_d = src_q;
    msk_d = msk_q;
    addr_d = addr_q;
    buf_d = buf_q;
    base_d = base_q;
    rlim_d = rlim_q;
    wlim_d = wlim_q;
    st_d = st_q;
    pidx_d = pidx_q;
    pwr_d = pwr_q;
    ack_d = 1'b0;
    ramreq_d = ramreq_q;
    hrd_d = hrd_q;
    ram_d = ram_q;
    prdata_d = prdata_q;

    // Controller side clears first so that host-side sets below win
    if (apb_wr) begin
      unique case (apb_req.paddr)
        EOFF_H2E: h2e_d = h2e_q & ~apb_req.pwdata[7:0];
        EOFF_E2H: begin
          e2h_d = apb_req.pwdata[7:0];
          src_d[SRC_ECWR_BIT] = 1'b1;
        end
        EOFF_E2H_CLR: e2h_d = e2h_q & ~apb_req.pwdata[7:0];
        EOFF_SRC: src_d[15:1] = src_q[15:1] | apb_req.pwdata[15:1];
        EOFF_MSK: msk_d = apb_req.pwdata[15:0];
        default: begin
          for (int r = 0; r < 2; r++) begin
            if (apb_req.paddr == EOFF_RGN + 8'(r) * EOFF_RGN_STRIDE) begin
              base_d[r] = apb_req.pwdata[15:0];
            end
            if (apb_req.paddr == EOFF_RGN + 8'(r) * EOFF_RGN_STRIDE + 8'h04) begin
              rlim_d[r] = apb_req.pwdata[15:0];
              wlim_d[r] = apb_req.pwdata[31:16];
            end
          end
        end
      endcase
    end
    if (apb_rd && apb_req.paddr == EOFF_H2E) begin
      h2e_irq_d = 1'b0;
    end
    if (apb_setup) begin
      prdata_d = WORD_RST;
      unique case (apb_req.paddr)
        EOFF_H2E: prdata_d[7:0] = h2e_q;
        EOFF_E2H, EOFF_E2H_CLR: prdata_d[7:0] = e2h_q;
        EOFF_SRC: prdata_d[15:0] = src_q;
        EOFF_MSK: prdata_d[15:0] = msk_q;
        default: begin
          for (int r = 0; r < 2; r++) begin
            if (apb_req.paddr == EOFF_RGN + 8'(r) * EOFF_RGN_STRIDE) begin
              prdata_d[15:0] = base_q[r];
            end
            if (apb_req.paddr == EOFF_RGN + 8'(r) * EOFF_RGN_STRIDE + 8'h04) begin
              prdata_d = {wlim_q[r], rlim_q[r]};
            end
          end
        end
      endcase
    end

    // Host port
    unique case (st_q)
      ST_IDLE: begin
        if (accept) begin
          pidx_d = idx;
          pwr_d = host_cmd.wr;
          if (is_data) begin
            if (last && inc) begin
              addr_d[14:2] = addr_q[14:2] + 13'h0001;
            end
            if (host_cmd.wr) begin
              buf_d = wmerge;
              if (last && wr_ok) begin
                ram_d.we = 1'b1;
                ram_d.addr = base_q[rsel] + {1'b0, blk_off[14:2], 2'b00};
                ram_d.be = be;
                ram_d.wdata = wmerge;
                ramreq_d = 1'b1;
                st_d = ST_RAM;
              end else begin
                ack_d = 1'b1;
              end
            end else if (first && rd_ok) begin
              ram_d.we = 1'b0;
              ram_d.addr = base_q[rsel] + {1'b0, blk_off[14:2], 2'b00};
              ram_d.be = be;
              ramreq_d = 1'b1;
              st_d = ST_RAM;
            end else begin
              if (first) begin
                buf_d = WORD_RST;
              end
              hrd_d = first ? 8'h00 : buf_q[8*idx +: 8];
              ack_d = 1'b1;
            end
          end else begin
            ack_d = 1'b1;
            hrd_d = 8'h00;
            unique case (host_cmd.addr)
              HOFF_H2E: begin
                hrd_d = h2e_q;
                if (host_cmd.wr) begin
                  h2e_d = host_cmd.wdata;
                  h2e_irq_d = 1'b1;
                end
              end
              HOFF_E2H: begin
                hrd_d = e2h_q;
                if (host_cmd.wr) begin
                  e2h_d = e2h_d & ~host_cmd.wdata;
                end else if (!(apb_wr && apb_req.paddr == EOFF_E2H)) begin
                  src_d[SRC_ECWR_BIT] = 1'b0;
                end
              end
              HOFF_ADDR0: begin
                hrd_d = addr_q[7:0];
                if (host_cmd.wr) addr_d[7:0] = host_cmd.wdata;
              end
              HOFF_ADDR1: begin
                hrd_d = addr_q[15:8];
                if (host_cmd.wr) addr_d[15:8] = host_cmd.wdata;
              end
              HOFF_SRC0: begin
                hrd_d = src_q[7:0];
                if (host_cmd.wr) src_d[7:0] = src_q[7:0] & ~host_cmd.wdata | src_set[7:0];
              end
              HOFF_SRC1: begin
                hrd_d = src_q[15:8];
                if (host_cmd.wr) src_d[15:8] = src_q[15:8] & ~host_cmd.wdata | src_set[15:8];
              end
              HOFF_MSK0: begin
                hrd_d = msk_q[7:0];
                if (host_cmd.wr) msk_d[7:0] = host_cmd.wdata;
              end
              HOFF_MSK1: begin
                hrd_d = msk_q[15:8];
                if (host_cmd.wr) msk_d[15:8] = host_cmd.wdata;
              end
              default: hrd_d = 8'h00;
            endcase
          end
        end
      end
      ST_RAM: begin
        if (ram_ack) begin
          ramreq_d = 1'b0;
          if (!pwr_q) begin
            buf_d = ram_rdata;
            hrd_d = ram_rdata[8*pidx_q +: 8];
          end
          st_d = ST_ACK;
        end
      end
      ST_ACK: begin
        ack_d = 1'b1;
        st_d = ST_IDLE;
      end
      default: st_d = ST_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      h2e_q <= MBOX_RST;
      h2e_irq_q <= 1'b0;
      e2h_q <= MBOX_RST;
      src_q <= REG16_RST;
      msk_q <= REG16_RST;
      addr_q <= REG16_RST;
      buf_q <= WORD_RST;
      for (int r = 0; r < 2; r++) begin
        base_q[r] <= REG16_RST;
        rlim_q[r] <= REG16_RST;
        wlim_q[r] <= REG16_RST;
      end
      st_q <= ST_IDLE;
      pidx_q <= 2'b00;
      pwr_q <= 1'b0;
      ack_q <= 1'b0;
      ramreq_q <= 1'b0;
      hrd_q <= 8'h00;
      ram_q <= '0;
      prdata_q <= WORD_RST;
    end else if (clk_en) begin
      h2e_q <= h2e_d;
      h2e_irq_q <= h2e_irq_d;
      e2h_q <= e2h_d;
      src_q <= src_d;
      msk_q <= msk_d;
      addr_q <= addr_d;
      buf_q <= buf_d;
      base_q <= base_d;
      rlim_q <= rlim_d;
      wlim_q <= wlim_d;
      st_q <= st_d;
      pidx_q <= pidx_d;
      pwr_q <= pwr_d;
      ack_q <= ack_d;
      ramreq_q <= ramreq_d;
      hrd_q <= hrd_d;
      ram_q <= ram_d;
      prdata_q <= prdata_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign host_ack = ack_q;
  assign host_rdata = hrd_q;
  assign prdata = prdata_q;
  assign pready = apb_req.psel && apb_req.penable;
  assign pslverr = apb_req.psel && apb_req.penable && !apb_hit;
  assign ram_req = ramreq_q;
  assign ram_cmd = ram_q;
  assign window_ec_irq_bit = h2e_irq_q;
  assign mailbox_event_line = src_q[SRC_ECWR_BIT];
  assign soft_irq_event_line = |(src_q[15:1] & msk_q[15:1])
    || (src_q[SRC_ECWR_BIT] && msk_q[SRC_ECWR_BIT]);
  assign serirq_sel0_level = src_q[SRC_ECWR_BIT];
  assign serirq_sel1_n = !soft_irq_event_line;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  h2e_irq_set_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    clk_en && accept && host_cmd.wr && host_cmd.addr == HOFF_H2E |=> window_ec_irq_bit)
    else $error("host mailbox write did not raise controller interrupt");
  e2h_flag_set_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    clk_en && apb_wr && apb_req.paddr == EOFF_E2H |=> mailbox_event_line && serirq_sel0_level)
    else $error("controller mailbox write did not raise event line");
  soft_evt_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    |(src_q[15:1] & msk_q[15:1]) |-> !serirq_sel1_n && soft_irq_event_line)
    else $error("enabled soft bit did not assert soft event");
  wr_evt_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    clk_en && apb_wr && apb_req.paddr == EOFF_E2H && msk_q[SRC_ECWR_BIT]
      && !(accept && host_cmd.wr && host_cmd.addr == HOFF_MSK0) |=> soft_irq_event_line)
    else $error("mailbox write with enable did not assert soft event");
  e2h_clr_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    clk_en && apb_wr && apb_req.paddr == EOFF_E2H_CLR && !accept
      |=> (e2h_q & $past(apb_req.pwdata[7:0])) == 8'h00)
    else $error("mailbox clear by one left bit set");
  ram_rd_done_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    clk_en && st_q == ST_RAM && ram_ack && !pwr_q |=> hrd_q == $past(ram_rdata[8*pidx_q +: 8]))
    else $error("host read data does not match RAM word");
  wr_limit_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    clk_en && accept && is_data && host_cmd.wr && !wr_ok |=> !ram_req && host_ack)
    else $error("write beyond write limit reached RAM");
  rd_limit_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    clk_en && accept && is_data && !host_cmd.wr && first && !rd_ok
      |=> !ram_req && host_ack && host_rdata == 8'h00)
    else $error("read beyond read limit did not return zero");
  autoinc_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    clk_en && accept && is_data && last && inc && !host_cmd.wr
      |=> addr_q[14:2] == $past(addr_q[14:2]) + 13'h0001)
    else $error("auto-increment did not step one block");

endmodule

`default_nettype wire

// ---- verif/hemwm_host_model.sv ----
// Host processor model issuing byte-wide I/O cycles to the window block
`timescale 1ns/1ps
`default_nettype none
module hemwm_host_model (
  input wire logic clk_sys,
  output logic host_req,
  output hemwm_pkg::hemwm_host_req_t host_cmd,
  input wire logic host_ack,
  input wire logic [7:0] host_rdata
);
  import hemwm_pkg::*;
  initial begin
    host_req = 1'b0;
    host_cmd = '0;
  end
  // One byte cycle; the command is scrambled once it is released
  task automatic access(input logic wr, input logic [3:0] a, input logic [7:0] d,
      output logic [7:0] q, output bit ok);
    int n;
    ok = 1'b0;
    q = 8'h00;
    @(posedge clk_sys);
    host_req <= 1'b1;
    host_cmd <= '{wr: wr, addr: a, wdata: d};
    for (n = 0; n < 64 && !ok; n++) begin
      @(posedge clk_sys);
      if (host_ack === 1'b1) begin
        ok = 1'b1;
        q = host_rdata;
      end
    end
    host_req <= 1'b0;
    host_cmd <= '{wr: ~wr, addr: ~a, wdata: ~d};
  endtask
endmodule
`default_nettype wire

// ---- verif/test_host_ec_memory_window_mailbox.sv ----
// Self-checking bench for the host memory window and mailbox block
`timescale 1ns/1ps
`default_nettype none
module test_host_ec_memory_window_mailbox;
  import hemwm_pkg::*;
  logic clk_sys, rst_b, clk_en, host_req, host_ack, pready, pslverr, ram_req, ram_ack;
  logic window_ec_irq_bit, mailbox_event_line, soft_irq_event_line, serirq_sel0_level;
  logic serirq_sel1_n;
  logic [7:0] host_rdata;
  logic [31:0] prdata, ram_rdata;
  hemwm_host_req_t host_cmd;
  hemwm_apb_req_t apb_req;
  hemwm_ram_req_t ram_cmd;
  logic [7:0] ram [0:4095];
  logic [7:0] exp_mem [0:4095];
  logic [7:0] m_buf [0:3];
  logic [15:0] m_addr, s, m;
  int base [0:1], rlim [0:1], wlim [0:1];
  int errors, samples_checked, lat, b, i, k;

  hemwm_top hemwm_top_inst (.clk_sys(clk_sys), .rst_b(rst_b), .clk_en(clk_en),
    .host_req(host_req), .host_cmd(host_cmd), .host_ack(host_ack), .host_rdata(host_rdata),
    .apb_req(apb_req), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ram_req(ram_req), .ram_cmd(ram_cmd), .ram_ack(ram_ack), .ram_rdata(ram_rdata),
    .window_ec_irq_bit(window_ec_irq_bit), .mailbox_event_line(mailbox_event_line),
    .soft_irq_event_line(soft_irq_event_line), .serirq_sel0_level(serirq_sel0_level),
    .serirq_sel1_n(serirq_sel1_n));
  hemwm_host_model hemwm_host_model_inst (.clk_sys(clk_sys), .host_req(host_req),
    .host_cmd(host_cmd), .host_ack(host_ack), .host_rdata(host_rdata));

  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  // --------------------------------------------------------------
  // RAM behind the direct port, random latency
  // --------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (ram_ack) begin
      ram_ack <= 1'b0;
      ram_rdata <= ~ram_rdata;
    end else if (ram_req === 1'b1 && lat == 0) begin
      for (b = 0; b < 4; b++) begin
        if (ram_cmd.we && ram_cmd.be[b]) ram[12'(ram_cmd.addr + b)] = ram_cmd.wdata[8*b+:8];
        ram_rdata[8*b+:8] <= ram[12'(ram_cmd.addr + b)];
      end
      ram_ack <= 1'b1;
      lat <= $urandom_range(2, 0);
    end else if (ram_req === 1'b1) lat <= lat - 1;
    else ram_rdata <= ~ram_rdata;
  end

  // --------------------------------------------------------------
  // Checking and closing
  // --------------------------------------------------------------
  task automatic chk(logic [31:0] seen, logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic fail();
    errors++;
    $display("BAD t=%0t no answer", $time);
    close_out();
  endtask
  task automatic ev(logic [4:0] e);
    @(posedge clk_sys);
    chk({window_ec_irq_bit, mailbox_event_line, soft_irq_event_line, serirq_sel0_level,
      serirq_sel1_n}, e);
  endtask
  task automatic do_reset();
    rst_b <= 1'b0;
    repeat (12) @(posedge clk_sys);
    rst_b <= 1'b1;
    m_addr = 16'h0000;
    base = '{0, 0};
    rlim = '{0, 0};
    wlim = '{0, 0};
  endtask
  task automatic apb(bit w, logic [7:0] a, logic [31:0] d, logic [31:0] e, bit err);
    int n;
    bit ok;
    ok = 1'b0;
    @(posedge clk_sys);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge clk_sys);
    apb_req.penable <= 1'b1;
    for (n = 0; n < 64 && !ok; n++) begin
      @(posedge clk_sys);
      if (pready === 1'b1) begin
        ok = 1'b1;
        if (!w) chk(prdata, e);
        chk(pslverr, err);
      end
    end
    apb_req <= '{psel: 1'b0, penable: 1'b0, pwrite: ~w, paddr: ~a, pwdata: ~d};
    if (!ok) fail();
  endtask

  // --------------------------------------------------------------
  // Reference model of the data window
  // --------------------------------------------------------------
  task automatic data_acc(int idx, bit wr, logic [7:0] d, output logic [7:0] e);
    int md, rg, off, lo, hi, st, j;
    md = m_addr[1:0];
    rg = m_addr[15];
    off = {m_addr[14:2], 2'b00};
    lo = md == 0 ? idx : md == 1 ? (idx & 2) : 0;
    hi = md == 0 ? idx : md == 1 ? lo + 1 : 3;
    st = off + lo;
    if (!wr && idx == lo) for (j = 0; j < 4; j++)
      m_buf[j] = st < rlim[rg] ? exp_mem[12'(base[rg] + off + j)] : 8'h00;
    if (wr) m_buf[idx] = d;
    if (wr && idx == hi && st < wlim[rg]) for (j = lo; j <= hi; j++)
      exp_mem[12'(base[rg] + off + j)] = m_buf[j];
    e = m_buf[idx];
    if (md == 3 && idx == hi) m_addr[14:2] = m_addr[14:2] + 13'h0001;
  endtask
  task automatic hio(bit wr, logic [3:0] a, logic [7:0] d, logic [7:0] x);
    logic [7:0] e, q;
    bit ok;
    e = x;
    if (a >= 4 && a <= 7) data_acc(a - 4, wr, d, e);
    if (wr && a == 2) m_addr[7:0] = d;
    if (wr && a == 3) m_addr[15:8] = d;
    hemwm_host_model_inst.access(wr, a, d, q, ok);
    if (!ok) fail();
    else if (!wr) chk(q, e);
  endtask
  task automatic ram_cmp();
    for (k = 0; k < 4096; k++) chk(ram[k], exp_mem[k]);
  endtask
  task automatic rgn(int r, int bs, int rl, int wl);
    apb(1, 8'h14 + 8'(8 * r), bs, 0, 0);
    apb(1, 8'h18 + 8'(8 * r), {16'(wl), 16'(rl)}, 0, 0);
    apb(0, 8'h18 + 8'(8 * r), 0, {16'(wl), 16'(rl)}, 0);
    base[r] = bs;
    rlim[r] = rl;
    wlim[r] = wl;
  endtask

  initial begin
    errors = 0;
    samples_checked = 0;
    rst_b = 1'b0;
    clk_en = 1'b1;
    apb_req = '0;
    ram_ack = 1'b0;
    ram_rdata = 32'h00000000;
    lat = 0;
    void'($urandom(32'h3D92B5A7));
    for (i = 0; i < 4096; i++) begin
      ram[i] = 8'($urandom);
      exp_mem[i] = ram[i];
    end
    do_reset();
    ev(5'h01);
    hio(1, 0, 8'h5A, 0);
    ev(5'h11);
    apb(0, 8'h00, 0, 32'h5A, 0);
    ev(5'h01);
    hio(1, 4'hA, 8'h01, 0);
    apb(1, 8'h04, 32'hC3, 0, 0);
    ev(5'h0E);
    hio(0, 1, 0, 8'hC3);
    ev(5'h01);
    hio(1, 1, 8'h03, 0);
    hio(0, 1, 0, 8'hC0);
    apb(1, 8'h08, 32'h40, 0, 0);
    apb(0, 8'h04, 0, 32'h80, 0);
    apb(0, 8'h24, 0, 0, 1);
    $display("test mailboxes done");
    for (i = 0; i < 6; i++) begin
      s = 16'($urandom) & 16'hFFFE;
      m = 16'($urandom);
      apb(1, 8'h0C, s, 0, 0);
      hio(1, 4'hA, m[7:0], 0);
      hio(1, 4'hB, m[15:8], 0);
      ev({2'b00, |(s & m), 1'b0, ~|(s & m)});
      hio(0, 4'h9, 0, s[15:8]);
      hio(1, 4'h8, s[7:0], 0);
      hio(1, 4'h9, s[15:8], 0);
      apb(0, 8'h0C, 0, 0, 0);
    end
    clk_en <= 1'b0;
    apb(1, 8'h0C, 32'h00000002, 0, 0);
    clk_en <= 1'b1;
    apb(0, 8'h0C, 0, 0, 0);
    $display("test soft events done");
    rgn(0, 16'h0100, 16'h0040, 16'h0080);
    rgn(1, 16'h0800, 0, 16'h0010);
    hio(1, 3, 8'h00, 0);
    hio(1, 2, 8'h03, 0);
    for (i = 0; i < 12; i++) hio(1, 4'(4 + i % 4), 8'($urandom), 0);
    ram_cmp();
    hio(1, 2, 8'h03, 0);
    for (i = 0; i < 12; i++) hio(0, 4'(4 + i % 4), 0, 0);
    for (k = 0; k < 3; k++) begin
      hio(1, 2, 8'(8'h10 | k), 0);
      for (i = 0; i < 4; i++) hio(1, 4'(4 + i), 8'($urandom), 0);
      for (i = 3; i >= 0; i--) hio(0, 4'(4 + i), 0, 0);
    end
    ram_cmp();
    hio(1, 2, 8'h21, 0);
    hio(0, 4, 0, 0);
    ram[12'h121] = ~ram[12'h121];
    exp_mem[12'h121] = ram[12'h121];
    hio(0, 5, 0, 0);
    hio(1, 2, 8'h42, 0);
    for (i = 0; i < 4; i++) hio(0, 4'(4 + i), 0, 0);
    hio(1, 2, 8'h82, 0);
    for (i = 0; i < 4; i++) hio(1, 4'(4 + i), 8'($urandom), 0);
    hio(1, 3, 8'h80, 0);
    hio(1, 2, 8'h02, 0);
    for (i = 0; i < 4; i++) hio(1, 4'(4 + i), 8'($urandom), 0);
    for (i = 0; i < 4; i++) hio(0, 4'(4 + i), 0, 0);
    ram_cmp();
    $display("test window done");
    do_reset();
    ev(5'h01);
    for (i = 0; i < 12; i++) hio(0, 4'(i), 0, 0);
    for (i = 0; i <= 32; i += 4) apb(0, 8'(i), 0, 0, 0);
    $display("test reset done");
    close_out();
  end
endmodule
`default_nettype wire
